// *** sma_pkg.sv ***
// Shared constants, types and framing functions for the serial unit
package sma_pkg;
   localparam logic [2:0] A_MODE = 3'h0;
   localparam logic [2:0] A_DIV  = 3'h1;
   localparam logic [2:0] A_CTRL = 3'h2;
   localparam logic [2:0] A_TXD  = 3'h3;
   localparam logic [2:0] A_STAT = 3'h4;
   localparam logic [2:0] A_RXD  = 3'h5;
   localparam logic [2:0] A_SERIAL_TIMER_CONTROL = 3'h6;
   localparam logic [2:0] A_DBL  = 3'h7;
   localparam int MODE_SYNC = 7;
   localparam int MODE_CHR  = 6;
   localparam int MODE_PE   = 5;
   localparam int MODE_OE   = 4;
   localparam int MODE_STOP = 3;
   localparam int MODE_MP   = 2;
   localparam int CTRL_LINE = 7;
   localparam int CTRL_TE   = 5;
   localparam int CTRL_RE   = 4;
   localparam int CTRL_CLOCK_ENABLE_HI = 1;
   localparam int CTRL_CLOCK_ENABLE_LO = 0;
   localparam int STAT_TDRE = 7;
   localparam int STAT_RDRF = 6;
   localparam int STAT_OVERRUN_ERROR_FLAG = 5;
   localparam int STAT_FER  = 4;
   localparam int STAT_PER  = 3;
   localparam int STAT_TEND = 2;
   localparam int STAT_MPB  = 1;
   localparam int STAT_MPBT = 0;
   localparam int SERIAL_TIMER_CONTROL_MPE  = 2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] PH_MID   = 4'h7;
   localparam logic [3:0] PH_LAST  = 4'hF;
   localparam logic [3:0] SYNC_LEN = 4'h8;
   localparam logic [6:0] PRE_1    = 7'h00;
   localparam logic [6:0] PRE_4    = 7'h03;
   localparam logic [6:0] PRE_16   = 7'h0F;
   localparam logic [6:0] PRE_64   = 7'h3F;
   localparam logic [6:0] PRE_8    = 7'h07;
   localparam logic [6:0] PRE_32   = 7'h1F;
   localparam logic [6:0] PRE_128  = 7'h7F;

   typedef struct packed {
      logic [3:0]  len;
      logic [11:0] bits;
   } sma_frame_t;

   function automatic logic sma_par(input logic [7:0] data, input logic char7, input logic odd);
      return ^(char7 ? {1'b0, data[6:0]} : data) ^ odd;
   endfunction

   function automatic sma_frame_t sma_frame(input logic [7:0] data, input logic sync, input logic char7,
                                            input logic pb_on, input logic pb, input logic two);
      sma_frame_t f;
      logic [3:0] dl;
      f.bits = 12'hFFF;
      dl     = char7 ? 4'h7 : 4'h8;
      if (sync) begin
         f.bits = {4'hF, data};
         f.len  = SYNC_LEN;
      end else begin
         f.bits[0] = 1'b0;
         for (int i = 0; i < 8; i++) begin
            if (i < int'(dl)) f.bits[i + 1] = data[i];
         end
         if (pb_on) f.bits[dl + 4'h1] = pb;
         f.len = 4'h1 + dl + {3'h0, pb_on} + (two ? 4'h2 : 4'h1);
      end
      return f;
   endfunction
endpackage

// *** sma_if.sv ***
// Serial link between the unit and the remote station
`timescale 1ns/10ps
interface sma_if;
   logic dev_txd;
   logic far_txd;
   logic dev_sck;
   logic dev_sck_oe;
   logic far_sck;
   logic far_sck_oe;
   logic sck_line;

   // Clock wire level, pulled high when nobody drives
   assign sck_line = dev_sck_oe ? dev_sck : (far_sck_oe ? far_sck : 1'b1);

   modport dev (output dev_txd, output dev_sck, output dev_sck_oe, input far_txd, input sck_line);
   modport far (output far_txd, output far_sck, output far_sck_oe, input dev_txd, input sck_line);
endinterface

// *** sma_brg.sv ***
// Baud rate generator: prescaler then divisor, one tick per 16x interval
`timescale 1ns/10ps
module sma_brg
   import sma_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [1:0] presel_i,
   input  wire logic       double_i,
   input  wire logic [7:0] divisor_i,
   output logic            tick_o
);
   import sma_pkg::*;

   typedef struct packed {
      logic [6:0] pre;
      logic [8:0] cnt;
      logic       tick;
   } sma_brg_st_t;

   sma_brg_st_t q, d;
   logic [6:0]  pre_lim;

   always_comb begin
      d = q;
      case (presel_i)
         2'h1:    pre_lim = double_i ? PRE_8 : PRE_4;
         2'h2:    pre_lim = double_i ? PRE_32 : PRE_16;
         2'h3:    pre_lim = double_i ? PRE_128 : PRE_64;
         default: pre_lim = PRE_1;
      endcase
      d.tick = 1'b0;
      if (q.pre >= pre_lim) begin
         d.pre = 7'h00;
         if (q.cnt >= {divisor_i, 1'b1}) begin
            d.cnt  = 9'h000;
            d.tick = 1'b1;
         end else begin
            d.cnt = q.cnt + 9'h001;
         end
      end else begin
         d.pre = q.pre + 7'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) q <= '0;
      else q <= d;
   end

   assign tick_o = q.tick;
endmodule // sma_brg

// *** sma_dev.sv ***
// Serial unit: registers, mode and clock selection, transmitter, receiver
`timescale 1ns/10ps
// What this block does
// - Shared control byte resets zero, fully read/write
// - Multiprocessor enable low disables multiprocessor format
// - Enable high plus format select picks multiprocessor
// - Mode bit 7: async zero, sync one
// - Async length bit: 8 or 7 data bits
// - Parity enable adds parity; stop bit one/two
// - Async receive flags framing, parity, overrun
// - Internal async timing from generator, clock out
// - Far end supplies 16x clock when external
// - Sync mode: fixed 8 bits, no extras
// - Sync receive checks overrun only
// - Sync internal: drive generator clock on pin
// - Sync external: shift on far end clock
// - Async clock bits: port pin or clock out
// - Async external: pin gives 16x clock
// - Async frames each character with start/stop
// - Independent double buffered transmit and receive
// - Line idles high, start is falling edge
// - Order: start, data LSB first, extra, stops
// - Receive samples each bit on 8th tick
// - Bit rate set by prescaler and divisor
// - Prescaler select and doubling choose division
module sma_dev
   import sma_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   sma_if.dev              link,
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       we_i,
   input  wire logic       re_i,
   output logic      [7:0] rdata_o
);
   import sma_pkg::*;

   typedef struct packed {
      logic [7:0]  mode;
      logic [7:0]  div;
      logic [7:0]  ctrl;
      logic [7:0]  serial_timer_control;
      logic        dbl;
      logic [7:0]  tdr;
      logic        tdre;
      logic        tend;
      logic        mpbt;
      logic [7:0]  rdr;
      logic        rdrf;
      logic        overrun_error_flag;
      logic        framing_error_flag;
      logic        parity_error_flag;
      logic        mpb;
      logic [7:0]  rdata;
      logic        tx_busy;
      logic [11:0] tx_sh;
      logic [3:0]  tx_left;
      logic [3:0]  tx_ph;
      logic        txd;
      logic        sck;
      logic        sck_oe;
      logic        rx_busy;
      logic [3:0]  rx_ph;
      logic [3:0]  rx_idx;
      logic [7:0]  rx_sh;
      logic        rx_pb;
      logic        rxd_m;
      logic        rxd;
      logic        sck_m;
      logic        sck_s;
      logic        sck_p;
   } sma_dev_st_t;

   sma_dev_st_t q, d;
   sma_frame_t  f;
   logic        brg_tick;
   logic        async_m;
   logic        ext;
   logic        mp_on;
   logic        char7;
   logic        pb_on;
   logic [3:0]  dl;
   logic        tick;
   logic        s_rise;
   logic        s_fall;
   logic        run;
   logic        adv;
   logic        ld;
   logic        tdr_wr;
   logic        err;
   logic        rx_done;
   logic        rx_fe;
   logic        rx_pe;
   logic [7:0]  rx_data;

   sma_brg u_brg (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .presel_i  (q.mode[1:0]),
      .double_i  (q.dbl),
      .divisor_i (q.div),
      .tick_o    (brg_tick)
   );

   always_comb begin
      d       = q;
      async_m = !q.mode[MODE_SYNC];
      ext     = q.ctrl[CTRL_CLOCK_ENABLE_HI];
      mp_on   = q.serial_timer_control[SERIAL_TIMER_CONTROL_MPE] && q.mode[MODE_MP] && async_m;
      char7   = q.mode[MODE_CHR] && async_m;
      pb_on   = (q.mode[MODE_PE] || mp_on) && async_m;
      dl      = char7 ? 4'h7 : 4'h8;
      run     = q.tx_busy || q.rx_busy;
      tick    = ext ? (q.sck_s && !q.sck_p) : brg_tick;
      s_rise  = ext ? (q.sck_s && !q.sck_p) : (brg_tick && !q.sck);
      s_fall  = ext ? (!q.sck_s && q.sck_p) : (brg_tick && q.sck && run);
      err     = q.overrun_error_flag || q.framing_error_flag || q.parity_error_flag;
      tdr_wr  = we_i && (addr_i == A_TXD);
      rx_done = 1'b0;
      rx_fe   = 1'b0;
      rx_pe   = 1'b0;
      rx_data = char7 ? {1'b0, q.rx_sh[6:0]} : q.rx_sh;
      f       = sma_frame(q.tdr, !async_m, char7, pb_on,
                          mp_on ? q.mpbt : sma_par(q.tdr, char7, q.mode[MODE_OE]), q.mode[MODE_STOP]);
      d.rxd_m = link.far_txd;
      d.rxd   = q.rxd_m;
      d.sck_m = link.sck_line;
      d.sck_s = q.sck_m;
      d.sck_p = q.sck_s;
      ////////////////////////////////////////////////////////////////////////////
      // Register access
      d.rdata = 8'h00;
      if (re_i) begin
         case (addr_i)
            A_MODE:  d.rdata = q.mode;
            A_DIV:   d.rdata = q.div;
            A_CTRL:  d.rdata = {q.rxd, q.ctrl[6:0]};
            A_TXD:   d.rdata = q.tdr;
            A_STAT:  d.rdata = {q.tdre, q.rdrf, q.overrun_error_flag, q.framing_error_flag, q.parity_error_flag, q.tend, q.mpb, q.mpbt};
            A_RXD:   d.rdata = q.rdr;
            A_SERIAL_TIMER_CONTROL:  d.rdata = q.serial_timer_control;
            default: d.rdata = {7'h00, q.dbl};
         endcase
      end
      if (we_i) begin
         case (addr_i)
            A_MODE:  d.mode = wdata_i;
            A_DIV:   d.div = wdata_i;
            A_CTRL:  d.ctrl = {1'b0, wdata_i[6:0]};
            A_TXD:   begin
               d.tdr  = wdata_i;
               d.tdre = 1'b0;
            end
            A_STAT:  begin
               d.mpbt = wdata_i[STAT_MPBT];
               if (wdata_i[STAT_RDRF]) d.rdrf = 1'b0;
               if (wdata_i[STAT_OVERRUN_ERROR_FLAG]) d.overrun_error_flag = 1'b0;
               if (wdata_i[STAT_FER]) d.framing_error_flag = 1'b0;
               if (wdata_i[STAT_PER]) d.parity_error_flag = 1'b0;
            end
            A_SERIAL_TIMER_CONTROL:  d.serial_timer_control = wdata_i;
            A_DBL:   d.dbl = wdata_i[0];
            default: d.dbl = q.dbl;
         endcase
      end
      ////////////////////////////////////////////////////////////////////////////
      // Transmitter
      if (async_m && tick) d.tx_ph = q.tx_ph + 4'h1;
      adv = async_m ? (tick && q.tx_ph == PH_LAST) : s_fall;
      ld  = 1'b0;
      if (!q.tx_busy) begin
         ld = q.ctrl[CTRL_TE] && !q.tdre && !tdr_wr;
      end else if (adv && q.tx_left != 4'h0) begin
         d.txd     = q.tx_sh[0];
         d.tx_sh   = {1'b1, q.tx_sh[11:1]};
         d.tx_left = q.tx_left - 4'h1;
      end else if ((async_m ? adv : s_rise) && q.tx_left == 4'h0) begin
         if (!q.tdre && !tdr_wr) begin
            ld = 1'b1;
         end else begin
            d.tx_busy = 1'b0;
            d.tend    = 1'b1;
         end
      end
      if (ld) begin
         d.tx_busy = 1'b1;
         d.tdre    = 1'b1;
         d.tend    = 1'b0;
         d.tx_sh   = f.bits;
         d.tx_left = f.len;
         if (q.tx_busy && async_m) begin
            d.txd     = f.bits[0];
            d.tx_sh   = {1'b1, f.bits[11:1]};
            d.tx_left = f.len - 4'h1;
         end
      end
      if (!q.ctrl[CTRL_TE]) begin
         d.tx_busy = 1'b0;
         d.tdre    = 1'b1;
         d.tend    = 1'b1;
         d.txd     = 1'b1;
      end
      ////////////////////////////////////////////////////////////////////////////
      // Receiver
      if (!q.ctrl[CTRL_RE] || err) begin
         d.rx_busy = 1'b0;
      end else if (async_m) begin
         if (tick && !q.rx_busy) begin
            if (!q.rxd) begin
               d.rx_busy = 1'b1;
               d.rx_ph   = 4'h0;
               d.rx_idx  = 4'h0;
            end
         end else if (tick) begin
            d.rx_ph = q.rx_ph + 4'h1;
            if (q.rx_ph == PH_MID) begin
               d.rx_idx = q.rx_idx + 4'h1;
               if (q.rx_idx == 4'h0) begin
                  if (q.rxd) d.rx_busy = 1'b0;
               end else if (q.rx_idx <= dl) begin
                  d.rx_sh[3'(q.rx_idx - 4'h1)] = q.rxd;
               end else if (q.rx_idx == dl + 4'h1 && pb_on) begin
                  d.rx_pb = q.rxd;
               end else begin
                  d.rx_busy = 1'b0;
                  rx_done   = 1'b1;
                  rx_fe     = !q.rxd;
                  rx_pe     = q.mode[MODE_PE] && !mp_on &&
                              (q.rx_pb != sma_par(rx_data, char7, q.mode[MODE_OE]));
               end
            end
         end
      end else if (!q.rx_busy) begin
         d.rx_busy = 1'b1;
         d.rx_idx  = 4'h0;
      end else if (s_rise) begin
         d.rx_sh[q.rx_idx[2:0]] = q.rxd;
         d.rx_idx = q.rx_idx + 4'h1;
         if (q.rx_idx == SYNC_LEN - 4'h1) begin
            d.rx_idx = 4'h0;
            rx_done  = 1'b1;
         end
      end
      if (rx_done) begin
         if (q.rdrf) begin
            d.overrun_error_flag = 1'b1;
         end else if (rx_fe || rx_pe) begin
            d.framing_error_flag = q.framing_error_flag || rx_fe;
            d.parity_error_flag = q.parity_error_flag || rx_pe;
            d.rdr = d.rx_sh;
         end else begin
            d.rdrf = 1'b1;
            d.rdr  = async_m ? (char7 ? {1'b0, d.rx_sh[6:0]} : d.rx_sh) : d.rx_sh;
            if (mp_on) d.mpb = q.rx_pb;
         end
      end
      ////////////////////////////////////////////////////////////////////////////
      // Serial clock pin
      if (async_m) begin
         d.sck_oe = !ext && q.ctrl[CTRL_CLOCK_ENABLE_LO];
         d.sck    = d.sck_oe ? q.tx_ph[3] : 1'b1;
      end else begin
         d.sck_oe = !ext;
         if (ext) d.sck = 1'b1;
         else if (brg_tick && (run || !q.sck)) d.sck = !q.sck;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q       <= '0;
         q.serial_timer_control  <= RST_BYTE;
         q.tdre  <= 1'b1;
         q.tend  <= 1'b1;
         q.txd   <= 1'b1;
         q.sck   <= 1'b1;
         q.tx_sh <= 12'hFFF;
         q.rxd_m <= 1'b1;
         q.rxd   <= 1'b1;
         q.sck_m <= 1'b1;
         q.sck_s <= 1'b1;
         q.sck_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign link.dev_txd    = q.txd;
   assign link.dev_sck    = q.sck;
   assign link.dev_sck_oe = q.sck_oe;
   assign rdata_o         = q.rdata;
endmodule // sma_dev

// *** sma_far.sv ***
// Remote station: simple serial partner for the unit
`timescale 1ns/10ps
module sma_far
   import sma_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   sma_if.far               link,
   input  wire logic [15:0] half_div_i,
   input  wire logic        char7_i,
   input  wire logic        par_en_i,
   input  wire logic        odd_i,
   input  wire logic        two_stop_i,
   input  wire logic        sync_i,
   input  wire logic        sck_drive_i,
   input  wire logic  [7:0] tx_data_i,
   input  wire logic        tx_valid_i,
   output logic             tx_ready_o,
   output logic       [7:0] rx_data_o,
   output logic             rx_valid_o,
   output logic             rx_err_o
);
   import sma_pkg::*;

   typedef struct packed {
      logic [15:0] div;
      logic        h;
      logic        txd;
      logic        sck;
      logic        sck_oe;
      logic        tx_free;
      logic [11:0] tx_sh;
      logic [3:0]  tx_left;
      logic [3:0]  tx_ph;
      logic        rx_busy;
      logic [3:0]  rx_ph;
      logic [3:0]  rx_idx;
      logic [7:0]  rx_sh;
      logic        rx_pb;
      logic [7:0]  rx_data;
      logic        rx_valid;
      logic        rx_err;
      logic        rxd_m;
      logic        rxd;
      logic        sck_m;
      logic        sck_s;
      logic        sck_p;
   } sma_far_st_t;

   sma_far_st_t q, d;
   sma_frame_t  f;
   logic        htog;
   logic        tick;
   logic        s_rise;
   logic        s_fall;
   logic [3:0]  dl;
   logic [7:0]  rdat;

   always_comb begin
      d          = q;
      dl         = char7_i ? 4'h7 : 4'h8;
      rdat       = char7_i ? {1'b0, q.rx_sh[6:0]} : q.rx_sh;
      f          = sma_frame(tx_data_i, sync_i, char7_i, par_en_i && !sync_i,
                             sma_par(tx_data_i, char7_i, odd_i), two_stop_i);
      d.rxd_m    = link.dev_txd;
      d.rxd      = q.rxd_m;
      d.sck_m    = link.sck_line;
      d.sck_s    = q.sck_m;
      d.sck_p    = q.sck_s;
      d.rx_valid = 1'b0;
      d.rx_err   = 1'b0;
      htog       = q.div >= half_div_i;
      d.div      = htog ? 16'h0000 : q.div + 16'h0001;
      if (htog) d.h = !q.h;
      tick       = htog && !q.h;
      s_rise     = sck_drive_i ? (tick && !q.tx_free) : (q.sck_s && !q.sck_p);
      s_fall     = sck_drive_i ? (htog && q.h && !q.tx_free) : (!q.sck_s && q.sck_p);
      // Clock pin: 16x in async, bit clock during sync transfers
      d.sck_oe   = sck_drive_i;
      d.sck      = sync_i ? (q.tx_free ? 1'b1 : d.h) : d.h;
      ////////////////////////////////////////////////////////////////////////////
      // Transmitter
      if (tick) d.tx_ph = q.tx_ph + 4'h1;
      if (q.tx_free) begin
         if (tx_valid_i) begin
            d.tx_free = 1'b0;
            d.tx_sh   = f.bits;
            d.tx_left = f.len;
         end
      end else if ((sync_i ? s_fall : tick && q.tx_ph == PH_LAST) && q.tx_left != 4'h0) begin
         d.txd     = q.tx_sh[0];
         d.tx_sh   = {1'b1, q.tx_sh[11:1]};
         d.tx_left = q.tx_left - 4'h1;
      end else if ((sync_i ? s_rise : tick && q.tx_ph == PH_LAST) && q.tx_left == 4'h0) begin
         d.tx_free = 1'b1;
      end
      ////////////////////////////////////////////////////////////////////////////
      // Receiver
      if (sync_i) begin
         if (s_rise) begin
            d.rx_sh[q.rx_idx[2:0]] = q.rxd;
            d.rx_idx = (q.rx_idx == SYNC_LEN - 4'h1) ? 4'h0 : q.rx_idx + 4'h1;
            if (q.rx_idx == SYNC_LEN - 4'h1) begin
               d.rx_valid = 1'b1;
               d.rx_data  = d.rx_sh;
            end
         end
      end else if (tick && !q.rx_busy) begin
         d.rx_idx = 4'h0;
         if (!q.rxd) begin
            d.rx_busy = 1'b1;
            d.rx_ph   = 4'h0;
            d.rx_idx  = 4'h0;
         end
      end else if (tick) begin
         d.rx_ph = q.rx_ph + 4'h1;
         if (q.rx_ph == PH_MID) begin
            d.rx_idx = q.rx_idx + 4'h1;
            if (q.rx_idx == 4'h0) begin
               if (q.rxd) d.rx_busy = 1'b0;
            end else if (q.rx_idx <= dl) begin
               d.rx_sh[3'(q.rx_idx - 4'h1)] = q.rxd;
            end else if (q.rx_idx == dl + 4'h1 && par_en_i) begin
               d.rx_pb = q.rxd;
            end else begin
               d.rx_busy  = 1'b0;
               d.rx_valid = 1'b1;
               d.rx_data  = rdat;
               d.rx_err   = !q.rxd || (par_en_i && q.rx_pb != sma_par(rdat, char7_i, odd_i));
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q         <= '0;
         q.txd     <= 1'b1;
         q.sck     <= 1'b1;
         q.tx_free <= 1'b1;
         q.tx_sh   <= 12'hFFF;
         q.rxd_m   <= 1'b1;
         q.rxd     <= 1'b1;
         q.sck_m   <= 1'b1;
         q.sck_s   <= 1'b1;
         q.sck_p   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign link.far_txd    = q.txd;
   assign link.far_sck    = q.sck;
   assign link.far_sck_oe = q.sck_oe;
   assign tx_ready_o      = q.tx_free;
   assign rx_data_o       = q.rx_data;
   assign rx_valid_o      = q.rx_valid;
   assign rx_err_o        = q.rx_err;
endmodule // sma_far

// *** sma_monitor.sv ***
// Checker on the wires between the unit and the remote station
`timescale 1ns/10ps
module sma_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic dev_txd,
   input wire logic far_txd,
   input wire logic dev_sck,
   input wire logic dev_sck_oe,
   input wire logic far_sck,
   input wire logic far_sck_oe,
   input wire logic sck_line
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   a_reset_idle: assert property ($rose(rst_n_i) |-> dev_txd && far_txd && !dev_sck_oe)
      else $error("link not idle after reset");
   a_dev_start: assert property ($fell(dev_txd) && !dev_sck_oe |-> ##31 !dev_txd)
      else $error("unit start bit short");
   a_far_start: assert property ($fell(far_txd) && !far_sck_oe && !dev_sck_oe |-> ##31 !far_txd)
      else $error("station start bit short");
   a_dev_hold: assert property ($changed(dev_txd) && !dev_sck_oe |=> $stable(dev_txd) [*8])
      else $error("unit bit cut short");
   a_far_hold: assert property ($changed(far_txd) && !dev_sck_oe && !far_sck_oe |=> $stable(far_txd) [*8])
      else $error("station bit cut short");
   a_no_contend: assert property (!(dev_sck_oe && far_sck_oe))
      else $error("clock driven from both ends");
   a_sck_pulled: assert property (!dev_sck_oe && !far_sck_oe |-> sck_line)
      else $error("undriven clock not high");
   a_sck_idle_high: assert property ($rose(dev_sck_oe) |-> dev_sck)
      else $error("clock output starts low");
endmodule // sma_monitor

// *** testbench.sv ***
// Self-checking bench: unit and remote station face to face
`timescale 1ns/10ps
module testbench;
   import sma_pkg::*;
   logic       clk_i, rst_n_i, we, re, re_q, fv, ready, rx_v, rx_e;
   logic       c7, pe, odd, two, sync, sdrv;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, d, last, far_d, rx_data;
   logic [7:0] exp_rd[$];
   logic [8:0] exp_rx[$];
   int         num_errors, n_checks;
   sma_if link ();
   sma_dev sma_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link.dev), .addr_i(addr),
      .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata));
   sma_far sma_far_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link.far), .half_div_i(16'h0000),
      .char7_i(c7), .par_en_i(pe), .odd_i(odd), .two_stop_i(two), .sync_i(sync), .sck_drive_i(sdrv),
      .tx_data_i(far_d), .tx_valid_i(fv), .tx_ready_o(ready), .rx_data_o(rx_data),
      .rx_valid_o(rx_v), .rx_err_o(rx_e));
   sma_monitor sma_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_txd(link.dev_txd),
      .far_txd(link.far_txd), .dev_sck(link.dev_sck), .dev_sck_oe(link.dev_sck_oe),
      .far_sck(link.far_sck), .far_sck_oe(link.far_sck_oe), .sck_line(link.sck_line));
   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end
   ////////////////////////////////////////
   task automatic chk(string nm, logic [8:0] e, logic [8:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] v);
      addr <= a;
      wdata <= v;
      we <= 1'h1;
      re <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] e);
      exp_rd.push_back(e);
      addr <= a;
      we <= 1'h0;
      re <= 1'h1;
      @(posedge clk_i);
   endtask
   task automatic wt(bit far_rx);
      we <= 1'h0;
      re <= 1'h0;
      fv <= 1'h0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk_i);
         if ((far_rx ? rx_v : ready) === 1'h1) return;
      end
      num_errors++;
      tally_and_finish();
   endtask
   always @(posedge clk_i) begin
      re_q <= re;
      if (re_q) chk("rdata", {1'h0, exp_rd.pop_front()}, {1'h0, rdata});
      if (rx_v === 1'h1) chk("far rx", exp_rx.pop_front(), {rx_e, rx_data});
   end
   ////////////////////////////////////////
   initial begin
      {rst_n_i, we, re, re_q, fv, c7, pe, odd, two, sync, sdrv} = '0;
      addr = '0;
      wdata = '0;
      far_d = '0;
      num_errors = 0;
      n_checks = 0;
      void'($urandom(32'h0A1B61FF));
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'h1;
      @(posedge clk_i);
      rd(A_SERIAL_TIMER_CONTROL, 8'h00);
      rd(A_STAT, 8'h84);
      d = 8'($urandom);
      wr(A_SERIAL_TIMER_CONTROL, d);
      rd(A_SERIAL_TIMER_CONTROL, d);
      rd(A_CTRL, 8'h80);
      for (int f = 0; f < 32; f++) begin
         logic [4:0] g;
         logic       mp;
         g = 5'(f);
         mp = g[4] & g[3];
         d = 8'($urandom);
         c7 <= g[0];
         pe <= g[1] | mp;
         odd <= g[3] & !mp;
         two <= g[2];
         exp_rx.push_back({1'h0, g[0] ? {1'h0, d[6:0]} : d});
         wr(A_CTRL, 8'h00);
         wr(A_MODE, {1'h0, g[0], g[1], g[3], g[2], g[4], 2'h0});
         wr(A_SERIAL_TIMER_CONTROL, {5'h00, mp, 2'h0});
         wr(A_STAT, {7'h00, ^(g[0] ? {1'h0, d[6:0]} : d)});
         wr(A_CTRL, 8'h20);
         wr(A_TXD, d);
         wt(1);
      end
      wr(A_CTRL, 8'h00);
      wr(A_MODE, 8'h20);
      wr(A_SERIAL_TIMER_CONTROL, 8'h00);
      wr(A_STAT, 8'h00);
      wr(A_CTRL, 8'h30);
      {c7, pe, two} <= 3'h2;
      for (int k = 0; k < 3; k++) begin
         d = 8'($urandom);
         if (k != 1) last = d;
         far_d <= d;
         odd <= (k == 2);
         fv <= 1'h1;
         we <= 1'h0;
         re <= 1'h0;
         @(posedge clk_i);
         wt(0);
         rd(A_STAT, k == 0 ? 8'hC4 : (k == 1 ? 8'hE4 : 8'h8C));
         rd(A_RXD, last);
         if (k == 1) wr(A_STAT, 8'h60);
      end
      // External 16x clock from the station
      wr(A_CTRL, 8'h00);
      wr(A_MODE, 8'h30);
      sdrv <= 1'h1;
      d = 8'($urandom);
      exp_rx.push_back({1'h0, d});
      wr(A_CTRL, 8'h22);
      wr(A_TXD, d);
      wt(1);
      sdrv <= 1'h0;
      wr(A_CTRL, 8'h00);
      wr(A_DIV, 8'h01);
      wr(A_DBL, 8'h01);
      wr(A_MODE, 8'h81);
      sync <= 1'h1;
      d = 8'($urandom);
      exp_rx.push_back({1'h0, d});
      wr(A_CTRL, 8'h20);
      wr(A_TXD, d);
      wt(1);
      tally_and_finish();
   end
endmodule // testbench
